// [rtl/bcr_pkg.sv]
package bcr_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // register map: three address lines pick one of eight word registers
  localparam int unsigned BCR_ADDR_W        = 3;
  localparam logic [7:0]  BCR_CTRL0_OFFSET  = 8'h00;
  localparam logic [7:0]  BCR_CTRL1_OFFSET  = 8'h04;
  localparam logic [BCR_ADDR_W-1:0] BCR_CTRL0_IDX = BCR_CTRL0_OFFSET[BCR_ADDR_W+1:2];
  localparam logic [BCR_ADDR_W-1:0] BCR_CTRL1_IDX = BCR_CTRL1_OFFSET[BCR_ADDR_W+1:2];

  // only the eight most significant data lines (bus bits 0..7) are wired
  localparam int unsigned BCR_LANE_W   = 8;
  localparam int unsigned BCR_LANE_MSB = 31;
  localparam int unsigned BCR_LANE_LSB = 24;

  ////////////////////////////////////////////////////////////////////////////////
  // field positions, in bus bit numbering (bit 0 is the most significant line)
  localparam int unsigned BCR_C0_CS_POL     = 0;
  localparam int unsigned BCR_C0_REQ_SEL    = 1;
  localparam int unsigned BCR_C0_REQ_TRI    = 2;
  localparam int unsigned BCR_C0_CH1_EN_N   = 3;
  localparam int unsigned BCR_C0_CH234_EN_N = 4;
  localparam int unsigned BCR_C0_FRAMER_RESET_N_N  = 5;
  localparam int unsigned BCR_C0_LED_GRN_N  = 6;
  localparam int unsigned BCR_C0_LED_RED_N  = 7;
  localparam int unsigned BCR_C1_BOOT_N     = 0;
  localparam int unsigned BCR_C1_CODEC_N    = 1;
  localparam int unsigned BCR_C1_CELL_N     = 2;
  localparam int unsigned BCR_C1_W          = 3;

  // power-on defaults, index k holds bus bit k
  localparam logic [7:0]          BCR_CTRL0_RESET = 8'hfc;
  localparam logic [BCR_C1_W-1:0] BCR_CTRL1_RESET = 3'h4;

  localparam int unsigned BCR_TDM_CH = 3;

  ////////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic                  cs_n;
    logic                  oe_n;
    logic                  we_n;
    logic [BCR_ADDR_W-1:0] addr;
  } bcr_bus_t;

  typedef struct packed {
    logic host_cs_polarity;
    logic host_req_ack_select;
    logic host_req_ack_tristate;
    logic framer_ch1_enable_n;
    logic framer_ch234_enable_n;
    logic framer_reset_n;
    logic led_green_n;
    logic led_red_n;
    logic serial_boot_route_n;
    logic codec_enable_n;
    logic cell_port_enable_n;
  } bcr_ctrl_t;

  // bus lane to field vector: lane bit 7 (line 0) becomes field index 0
  function automatic logic [7:0] bcr_swap8(input logic [7:0] v);
    logic [7:0] r;
    r = '0;
    for (int i = 0; i < 8; i++) begin
      r[i] = v[7-i];
    end
    return r;
  endfunction : bcr_swap8

endpackage : bcr_pkg

// [rtl/bcr_tdm_gate.sv]
`timescale 1ns/100ps
module bcr_tdm_gate
  import bcr_pkg::*;
(
  input  wire logic                        clk,
  input  wire logic                        rst,
  input  wire logic                        ch234_enable_n,
  input  wire logic [bcr_pkg::BCR_TDM_CH-1:0] framer_rx_data,
  input  wire logic [bcr_pkg::BCR_TDM_CH-1:0] framer_rx_clk,
  output logic      [bcr_pkg::BCR_TDM_CH-1:0] tdm_rx_data,
  output logic      [bcr_pkg::BCR_TDM_CH-1:0] tdm_rx_clk,
  output logic      [bcr_pkg::BCR_TDM_CH-1:0] tdm_rx_oe_n
);

  ////////////////////////////////////////////////////////////////////////////////
  // tri-state buffers of channels 2..4: only receive data and receive clock pass
  genvar g;
  generate
    for (g = 0; g < BCR_TDM_CH; g++) begin : g_ch
      assign tdm_rx_data[g] = framer_rx_data[g] & ~ch234_enable_n;
      assign tdm_rx_clk[g]  = framer_rx_clk[g]  & ~ch234_enable_n;
      assign tdm_rx_oe_n[g] = ch234_enable_n;
    end
  endgenerate

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_gate_isolate: assert property (ch234_enable_n |-> (tdm_rx_oe_n == '1 && tdm_rx_data == '0))
    else $error("isolated framer channels still drive the tdm ports");
  a_gate_pass: assert property (!ch234_enable_n |-> (tdm_rx_clk == framer_rx_clk))
    else $error("enabled framer receive clock not passed through");

endmodule : bcr_tdm_gate

// [rtl/bcr_board_ctrl.sv]
// Contract
// - only three address lines select a register; the eight repeat across the region.
// - control 0 uses only data lines 0..7, accessed as a word at offset 0.
// - both control registers take their defaults on power-on reset.
// - control 0 bit 0 picks host chip-select polarity: 0 low-active, 1 high.
// - control 0 bit 1 sets request/acknowledge buffer direction; 0 acknowledge, default 0.
// - control 0 bit 2 high tri-states the request/acknowledge buffer; default 1.
// - control 0 bit 3 low connects framer channel 1 to first tdm port; default 1.
// - control 0 bit 4 low routes framer channels 2..4; high isolates them; default 1.
// - only receive data and receive clock of channels 2..4 are gated.
// - control 0 bit 5 low or hard reset holds the framer reset; default 1.
// - bits 6 and 7 low light green and red lamps; both default 1.
// - control 1 is a word register at offset 4, readable and writable anytime.
// - control 1 bit 0 low or serial boot steers i2c to the boot eeprom.
// - control 1 bit 1 low connects the codec; high isolates it; default 0.
// - control 1 bit 2 low enables the cell port transceiver; default 1.
// - module enables from register bits also appear on the expansion outputs.
// - at power-on the codec is enabled and the other muxed peripherals disabled.
`timescale 1ns/100ps
module bcr_board_ctrl
  import bcr_pkg::*;
(
  input  wire logic                           clk,
  input  wire logic                           rst,
  input  wire bcr_pkg::bcr_bus_t              bus,
  input  wire logic [31:0]                    bus_data_in,
  output logic      [bcr_pkg::BCR_LANE_W-1:0] bus_data_out,
  output logic                                bus_data_oe_n,
  input  wire logic                           hard_reset_n,
  input  wire logic                           serial_boot_mode,
  input  wire logic                           host_select_a,
  input  wire logic                           host_select_global,
  output logic                                host_select_a_act,
  output logic                                host_select_global_act,
  input  wire logic [bcr_pkg::BCR_TDM_CH-1:0] framer_rx_data,
  input  wire logic [bcr_pkg::BCR_TDM_CH-1:0] framer_rx_clk,
  output logic      [bcr_pkg::BCR_TDM_CH-1:0] tdm_rx_data,
  output logic      [bcr_pkg::BCR_TDM_CH-1:0] tdm_rx_clk,
  output logic      [bcr_pkg::BCR_TDM_CH-1:0] tdm_rx_oe_n,
  output bcr_pkg::bcr_ctrl_t                  ctrl,
  output bcr_pkg::bcr_ctrl_t                  ctrl_exp
);

  import bcr_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // register state, index k holds bus bit k
  logic [7:0]          ctrl0_r;
  logic [BCR_C1_W-1:0] ctrl1_r;
  logic [7:0]          rd_lane_r;
  logic [7:0]          rd_lane_nxt;
  logic [7:0]          wr_field;
  logic                sel_ctrl0;
  logic                sel_ctrl1;
  logic                bus_wr;
  logic                bus_rd;

  // address decode: upper address bits are ignored, so the map aliases
  function automatic logic hit(input logic [BCR_ADDR_W-1:0] a,
                               input logic [BCR_ADDR_W-1:0] idx);
    return a == idx;
  endfunction : hit

  assign sel_ctrl0 = hit(bus.addr, BCR_CTRL0_IDX);
  assign sel_ctrl1 = hit(bus.addr, BCR_CTRL1_IDX);
  assign bus_wr    = !bus.cs_n && !bus.we_n;
  assign bus_rd    = !bus.cs_n && !bus.oe_n && bus.we_n;
  assign wr_field  = bcr_swap8(bus_data_in[BCR_LANE_MSB:BCR_LANE_LSB]);

  ////////////////////////////////////////////////////////////////////////////////
  // control register 0
  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl0_r <= BCR_CTRL0_RESET;
    end else if (bus_wr && sel_ctrl0) begin
      ctrl0_r <= wr_field;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // control register 1
  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl1_r <= BCR_CTRL1_RESET;
    end else if (bus_wr && sel_ctrl1) begin
      ctrl1_r <= wr_field[BCR_C1_W-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // read path: lane is refreshed every cycle from the current address, so it is
  // valid one cycle after address and chip select settle; no wait handshake
  always_comb begin
    rd_lane_nxt = '0;
    if (sel_ctrl0) begin
      rd_lane_nxt = bcr_swap8(ctrl0_r);
    end else if (sel_ctrl1) begin
      rd_lane_nxt = bcr_swap8({{(8-BCR_C1_W){1'b0}}, ctrl1_r});
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rd_lane_r <= '0;
    end else begin
      rd_lane_r <= rd_lane_nxt;
    end
  end

  assign bus_data_out  = rd_lane_r;
  // only lines 0..7 are ever driven, and only for the two implemented registers
  assign bus_data_oe_n = !(bus_rd && (sel_ctrl0 || sel_ctrl1));

  ////////////////////////////////////////////////////////////////////////////////
  // host port controls
  assign host_select_a_act      = ctrl0_r[BCR_C0_CS_POL] ? host_select_a
                                                         : !host_select_a;
  assign host_select_global_act = ctrl0_r[BCR_C0_CS_POL] ? host_select_global
                                                         : !host_select_global;

  ////////////////////////////////////////////////////////////////////////////////
  // module enables and resets
  always_comb begin
    ctrl.host_cs_polarity      = ctrl0_r[BCR_C0_CS_POL];
    ctrl.host_req_ack_select   = ctrl0_r[BCR_C0_REQ_SEL];
    ctrl.host_req_ack_tristate = ctrl0_r[BCR_C0_REQ_TRI];
    ctrl.framer_ch1_enable_n   = ctrl0_r[BCR_C0_CH1_EN_N];
    ctrl.framer_ch234_enable_n = ctrl0_r[BCR_C0_CH234_EN_N];
    ctrl.framer_reset_n        = ctrl0_r[BCR_C0_FRAMER_RESET_N_N] && hard_reset_n;
    ctrl.led_green_n           = ctrl0_r[BCR_C0_LED_GRN_N];
    ctrl.led_red_n             = ctrl0_r[BCR_C0_LED_RED_N];
    ctrl.serial_boot_route_n   = ctrl1_r[BCR_C1_BOOT_N] && !serial_boot_mode;
    ctrl.codec_enable_n        = ctrl1_r[BCR_C1_CODEC_N];
    ctrl.cell_port_enable_n    = ctrl1_r[BCR_C1_CELL_N];
  end

  // same enables presented at the expansion connectors for off-board hardware
  assign ctrl_exp = ctrl;

  ////////////////////////////////////////////////////////////////////////////////
  bcr_tdm_gate u_tdm_gate (
    .clk            (clk),
    .rst            (rst),
    .ch234_enable_n (ctrl0_r[BCR_C0_CH234_EN_N]),
    .framer_rx_data (framer_rx_data),
    .framer_rx_clk  (framer_rx_clk),
    .tdm_rx_data    (tdm_rx_data),
    .tdm_rx_clk     (tdm_rx_clk),
    .tdm_rx_oe_n    (tdm_rx_oe_n)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_wr0;
    bus_wr && bus.addr == BCR_CTRL0_IDX;
  endsequence
  sequence s_rd0_held;
    (bus_rd && bus.addr == BCR_CTRL0_IDX) [*2];
  endsequence
  sequence s_rd1_held;
    (bus_rd && bus.addr == BCR_CTRL1_IDX) [*2];
  endsequence

  a_reset_defaults: assert property (@(posedge clk) disable iff (1'b0)
      rst |=> (ctrl0_r == BCR_CTRL0_RESET && ctrl1_r == BCR_CTRL1_RESET))
    else $error("control registers missed their power-on defaults");
  a_power_on_mix: assert property (@(posedge clk) disable iff (1'b0)
      rst |=> (!ctrl.codec_enable_n && ctrl.cell_port_enable_n
               && ctrl.framer_ch1_enable_n && ctrl.framer_ch234_enable_n))
    else $error("power-on peripheral selection wrong");
  a_write_ctrl0: assert property (s_wr0 |=> ctrl0_r == $past(wr_field))
    else $error("write to control 0 not stored");
  a_write_ctrl1: assert property (
      bus_wr && bus.addr == BCR_CTRL1_IDX |=> ctrl1_r == $past(wr_field[BCR_C1_W-1:0]))
    else $error("write to control 1 not stored");
  a_alias_ignore: assert property (
      bus_wr && !sel_ctrl0 && !sel_ctrl1 |=> $stable(ctrl0_r) && $stable(ctrl1_r))
    else $error("write to another index altered control registers");
  a_read_ctrl0: assert property (
      s_rd0_held |-> !bus_data_oe_n && bus_data_out == bcr_swap8($past(ctrl0_r)))
    else $error("control 0 read data wrong");
  a_read_ctrl1: assert property (
      s_rd1_held |-> !bus_data_oe_n
                     && bus_data_out == bcr_swap8({{(8-BCR_C1_W){1'b0}}, $past(ctrl1_r)}))
    else $error("control 1 read data wrong");
  a_framer_hold: assert property (
      !hard_reset_n || !ctrl0_r[BCR_C0_FRAMER_RESET_N_N] |-> !ctrl.framer_reset_n)
    else $error("framer reset not asserted");
  a_boot_route: assert property (serial_boot_mode |-> !ctrl.serial_boot_route_n)
    else $error("serial boot did not steer i2c to eeprom");
  a_cs_polarity: assert property (
      host_select_a_act == (host_select_a ~^ ctrl0_r[BCR_C0_CS_POL]))
    else $error("host chip-select polarity wrong");
  a_exp_mirror: assert property (ctrl_exp == ctrl)
    else $error("expansion enables differ from on-board enables");

endmodule : bcr_board_ctrl

// [testbench/bcr_mc_model.sv]
`timescale 1ns/100ps
module bcr_mc_model
  import bcr_pkg::*;
(
  input  wire logic                           clk,
  output bcr_pkg::bcr_bus_t                   bus,
  output logic [31:0]                         bus_data_in,
  input  wire logic [bcr_pkg::BCR_LANE_W-1:0] bus_data_out,
  input  wire logic                           bus_data_oe_n
);
  initial begin
    bus         = '{cs_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, addr: 3'h0};
    bus_data_in = 32'h0000_0000;
  end
  // one taking edge per write; nothing comes back to stretch it
  task automatic write_word(input logic [2:0] idx, input logic [7:0] lane);
    @(posedge clk);
    #1;
    bus         = '{cs_n: 1'b0, oe_n: 1'b1, we_n: 1'b0, addr: idx};
    bus_data_in = {lane, 24'h5a_c3a5};
    @(posedge clk);
    #1;
    bus         = '{cs_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, addr: idx};
    bus_data_in = ~bus_data_in; // released lines do not keep the last value
  endtask : write_word
  // read held two cycles: lane registered after the first edge
  task automatic read_word(input logic [2:0] idx, output logic [7:0] lane, output logic oe_n);
    @(posedge clk);
    #1;
    bus = '{cs_n: 1'b0, oe_n: 1'b0, we_n: 1'b1, addr: idx};
    @(posedge clk);
    @(negedge clk);
    lane = bus_data_out;
    oe_n = bus_data_oe_n;
    @(posedge clk);
    #1;
    bus = '{cs_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, addr: idx};
  endtask : read_word
endmodule : bcr_mc_model

// [testbench/tb.sv]
`timescale 1ns/100ps
module tb;
  import bcr_pkg::*;
  logic                  clk;
  logic                  rst;
  logic                  hard_reset_n;
  logic                  serial_boot_mode;
  logic                  host_select_a;
  logic                  host_select_global;
  logic                  host_select_a_act;
  logic                  host_select_global_act;
  logic [BCR_TDM_CH-1:0] framer_rx_data;
  logic [BCR_TDM_CH-1:0] framer_rx_clk;
  logic [BCR_TDM_CH-1:0] tdm_rx_data;
  logic [BCR_TDM_CH-1:0] tdm_rx_clk;
  logic [BCR_TDM_CH-1:0] tdm_rx_oe_n;
  bcr_bus_t              bus;
  logic [31:0]           bus_data_in;
  logic [7:0]            bus_data_out;
  logic                  bus_data_oe_n;
  bcr_ctrl_t             ctrl;
  bcr_ctrl_t             ctrl_exp;
  int                    mismatches;
  int                    n_checks;
  logic [7:0]            lane;
  logic [7:0]            v;
  logic                  oe_n;
  logic [7:0]            c1_tab [6] = '{8'h00, 8'he0, 8'h80, 8'h40, 8'h20, 8'hff};

  bcr_board_ctrl bcr_board_ctrl_inst (.clk(clk), .rst(rst), .bus(bus),
    .bus_data_in(bus_data_in), .bus_data_out(bus_data_out), .bus_data_oe_n(bus_data_oe_n),
    .hard_reset_n(hard_reset_n), .serial_boot_mode(serial_boot_mode),
    .host_select_a(host_select_a), .host_select_global(host_select_global),
    .host_select_a_act(host_select_a_act), .host_select_global_act(host_select_global_act),
    .framer_rx_data(framer_rx_data), .framer_rx_clk(framer_rx_clk), .tdm_rx_data(tdm_rx_data),
    .tdm_rx_clk(tdm_rx_clk), .tdm_rx_oe_n(tdm_rx_oe_n), .ctrl(ctrl), .ctrl_exp(ctrl_exp));
  bcr_mc_model bcr_mc_model_inst (.clk(clk), .bus(bus), .bus_data_in(bus_data_in),
    .bus_data_out(bus_data_out), .bus_data_oe_n(bus_data_oe_n));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : conclude

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    rst = 1'b1;
    hard_reset_n = 1'b1;
    serial_boot_mode = 1'b0;
    host_select_a = 1'b0;
    host_select_global = 1'b1;
    framer_rx_data = 3'h5;
    framer_rx_clk = 3'h3;
    mismatches = 0;
    n_checks = 0;
    repeat (3) @(posedge clk);
    #1 rst = 1'b0;
    chk("ctrl", ctrl, 32'h0000_01f9);
    chk("ctrl_exp", ctrl_exp, 32'h0000_01f9);
    bcr_mc_model_inst.read_word(3'h0, lane, oe_n);
    chk("ctrl0 read", lane, 32'h0000_003f);
    chk("ctrl0 oe_n", oe_n, 32'h0000_0000);
    bcr_mc_model_inst.read_word(3'h1, lane, oe_n);
    chk("ctrl1 read", lane, 32'h0000_0020);
    $display("test defaults done");
    // walking one and walking zero over every control 0 field
    for (int i = 0; i < 16; i++) begin
      v = (i < 8) ? 8'(8'h01 << i) : ~8'(8'h01 << (i - 8));
      framer_rx_data = 3'(i);
      framer_rx_clk = ~3'(i);
      bcr_mc_model_inst.write_word(3'h0, v);
      chk("fields", ctrl[10:3], v);
      chk("exp fields", ctrl_exp[10:3], v);
      chk("tdm oe_n", tdm_rx_oe_n, {3{v[3]}});
      chk("tdm data", tdm_rx_data, v[3] ? 3'h0 : 3'(i));
      chk("tdm clk", tdm_rx_clk, v[3] ? 3'h0 : 3'(~i));
      for (int a = 0; a < 2; a++) begin
        host_select_a = a[0];
        host_select_global = ~a[0];
        #1;
        chk("sel a", host_select_a_act, v[7] ? a[0] : !a[0]);
        chk("sel g", host_select_global_act, v[7] ? !a[0] : a[0]);
      end
      bcr_mc_model_inst.read_word(3'h0, lane, oe_n);
      chk("ctrl0 read", lane, v);
    end
    hard_reset_n = 1'b0;
    #1;
    chk("framer reset", ctrl.framer_reset_n, 1'b0);
    hard_reset_n = 1'b1;
    #1;
    chk("framer reset", ctrl.framer_reset_n, 1'b1);
    $display("test control0 done");
    for (int k = 2; k < 8; k++) begin
      bcr_mc_model_inst.write_word(3'(k), 8'h00);
      bcr_mc_model_inst.read_word(3'(k), lane, oe_n);
      chk("unmapped oe_n", oe_n, 1'b1);
    end
    bcr_mc_model_inst.read_word(3'h0, lane, oe_n);
    chk("ctrl0 kept", lane, 32'h0000_007f);
    $display("test unmapped done");
    foreach (c1_tab[j]) begin
      v = c1_tab[j];
      bcr_mc_model_inst.write_word(3'h1, v);
      for (int sb = 0; sb < 2; sb++) begin
        serial_boot_mode = sb[0];
        #1;
        chk("boot route", ctrl.serial_boot_route_n, v[7] & ~sb[0]);
      end
      chk("codec", ctrl.codec_enable_n, v[6]);
      chk("cell port", ctrl.cell_port_enable_n, v[5]);
      chk("exp codec", ctrl_exp.codec_enable_n, v[6]);
      bcr_mc_model_inst.read_word(3'h1, lane, oe_n);
      chk("ctrl1 read", lane, v & 8'he0);
    end
    $display("test control1 done");
    @(posedge clk);
    #1 rst = 1'b1;
    @(posedge clk);
    #1 rst = 1'b0;
    chk("ctrl", ctrl, 32'h0000_01f9);
    $display("test second reset done");
    conclude();
  end
endmodule : tb
